//--- verilog/dfr_pkg.sv
// shared constants and types of the drive fault reaction selector
package dfr_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] DEV_CODE_IDX  = 16'h3700;
  localparam logic [15:0] LIM_CODE_IDX  = 16'h3701;
  localparam logic [15:0] CMD_WORD_IDX  = 16'h3702;
  localparam logic [15:0] STAT_WORD_IDX = 16'h3703;
  localparam logic [15:0] IRQ_STAT_IDX  = 16'h3704;
  localparam logic [15:0] IRQ_MASK_IDX  = 16'h3705;
  // reset values
  localparam logic [15:0] CODE_RST      = 16'hFFFF;
  localparam logic [15:0] CMD_RST       = 16'h0000;
  // option codes as 16-bit two's complement
  localparam logic [15:0] CODE_NONE     = 16'hFFFF;
  localparam logic [15:0] CODE_COAST    = 16'h0000;
  localparam logic [15:0] CODE_SLOW     = 16'h0001;
  localparam logic [15:0] CODE_QUICK    = 16'h0002;
  localparam logic [15:0] CODE_SLOW_HLT = 16'h0005;
  localparam logic [15:0] CODE_QUICK_HLT = 16'h0006;
  // field positions
  localparam int WARN_BIT   = 7;
  localparam int HALT_BIT   = 2;
  localparam int ENA_BIT    = 0;
  localparam int IRQ_DEV    = 0;
  localparam int IRQ_LIM    = 1;
  localparam int IRQ_RAMP   = 2;
  localparam int NUM_IRQ    = 3;
  localparam int NUM_PINS   = 4;
  localparam int PIN_FOLLOW = 0;
  localparam int PIN_SLIP   = 1;
  localparam int PIN_LIMIT  = 2;
  localparam int PIN_RAMP   = 3;

  // drive states
  typedef enum logic [4:0] {
    ST_RUN   = 5'b0_0001,
    ST_BRAKE = 5'b0_0010,
    ST_COAST = 5'b0_0100,
    ST_LOCK  = 5'b0_1000,
    ST_HALT  = 5'b1_0000
  } dfr_state_t;

  // decoded reaction
  typedef struct packed {
    logic act;
    logic coast;
    logic quick;
    logic toHalt;
  } dfr_react_t;

  // motion control outputs
  typedef struct packed {
    logic powerEn;
    logic brakeSlow;
    logic brakeQuick;
  } dfr_drive_t;
endpackage

//--- verilog/dfr_sync.sv
// two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module dfr_sync import dfr_pkg::*; #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // pins and synchronised levels
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dfr_sync_st_t;

  dfr_sync_st_t s_r;
  dfr_sync_st_t s_nxt;

  // first stage feeds only the second
  always_comb begin
    s_nxt        = s_r;
    s_nxt.meta   = pinIn;
    s_nxt.stable = s_r.meta;
  end

  // registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign syncOut = s_r.stable;
endmodule

//--- verilog/dfr_irq.sv
// sticky event status, mask and interrupt line
`timescale 1ns/1ps
module dfr_irq import dfr_pkg::*; (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // events and register writes
  input  wire logic [NUM_IRQ-1:0] setEv,
  input  wire logic               statWr,
  input  wire logic               maskWr,
  input  wire logic [NUM_IRQ-1:0] wrData,
  // state
  output logic      [NUM_IRQ-1:0] stat,
  output logic      [NUM_IRQ-1:0] mask,
  output logic                    irq
);
  typedef struct packed {
    logic [NUM_IRQ-1:0] stat;
    logic [NUM_IRQ-1:0] mask;
    logic               irq;
  } dfr_irq_st_t;

  dfr_irq_st_t s_r;
  dfr_irq_st_t s_nxt;

  // write one clears; a new event wins over its own clear
  always_comb begin
    s_nxt = s_r;
    if (statWr) begin
      s_nxt.stat = s_r.stat & ~wrData;
    end
    s_nxt.stat = s_nxt.stat | setEv;
    if (maskWr) begin
      s_nxt.mask = wrData;
    end
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
  end

  // registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign stat = s_r.stat;
  assign mask = s_r.mask;
  assign irq  = s_r.irq;
endmodule

//--- verilog/dfr_top.sv
// drive fault reaction selector with ahb-lite register slave
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module dfr_top import dfr_pkg::*; (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // fault and motion pins, asynchronous
  input  wire logic        followErr,
  input  wire logic        slipErr,
  input  wire logic        limitHit,
  input  wire logic        rampDone,
  // drive control
  output logic             powerEn,
  output logic             brakeSlow,
  output logic             brakeQuick,
  output logic [4:0]       driveState,
  output logic             warning,
  output logic             irq
);
  typedef struct packed {
    dfr_state_t           state;
    logic [15:0]          devCode;
    logic [15:0]          limCode;
    logic [15:0]          cmd;
    logic                 warn;
    logic                 haltLowSeen;
    logic                 enaPrev;
    logic                 toHalt;
    dfr_drive_t           drv;
    logic [NUM_PINS-1:0]  pinPrev;
    logic                 wrPend;
    logic [15:0]          wrIdx;
    logic [31:0]          rdata;
    logic                 ready;
    logic                 resp;
  } dfr_core_t;

  // register select, one field per mapped index
  typedef struct packed {
    logic dev;
    logic lim;
    logic cmd;
    logic stat;
    logic irqSt;
    logic irqMsk;
  } dfr_sel_t;

  dfr_core_t           s_r;
  dfr_core_t           s_nxt;
  logic [NUM_PINS-1:0] pinSync;
  logic [NUM_IRQ-1:0]  irqStat;
  logic [NUM_IRQ-1:0]  irqMask;
  logic                irqLine;
  logic [NUM_IRQ-1:0]  irqSet;
  logic [NUM_PINS-1:0] pinRise;
  logic                devEv;
  logic                limEv;
  logic                rampEv;
  logic                addrOk;
  logic [15:0]         addrIdx;
  logic                take;
  dfr_react_t          react;
  dfr_sel_t            wrSel;
  dfr_sel_t            rdSel;

  // map an option code to a reaction; unlisted codes are inert
  function automatic dfr_react_t decodeCode(input logic [15:0] code, input logic isLimit);
    dfr_react_t r;
    r = '0;
    if (!isLimit) begin
      if (code == CODE_COAST) begin
        r.act   = 1'b1;
        r.coast = 1'b1;
      end else if (code == CODE_SLOW) begin
        r.act = 1'b1;
      end else if (code == CODE_QUICK) begin
        r.act   = 1'b1;
        r.quick = 1'b1;
      end
    end else begin
      if (code == CODE_SLOW) begin
        r.act = 1'b1;
      end else if (code == CODE_QUICK) begin
        r.act   = 1'b1;
        r.quick = 1'b1;
      end else if (code == CODE_SLOW_HLT) begin
        r.act    = 1'b1;
        r.toHalt = 1'b1;
      end else if (code == CODE_QUICK_HLT) begin
        r.act    = 1'b1;
        r.quick  = 1'b1;
        r.toHalt = 1'b1;
      end
    end
    // minus one and reserved codes leave act low
    return r;
  endfunction

  // status word: warning flag and one-hot state
  function automatic logic [15:0] statusWord(input dfr_core_t c);
    logic [15:0] w;
    w           = 16'h0000;
    w[4:0]      = c.state;
    w[WARN_BIT] = c.warn;
    return w;
  endfunction

  // index decode shared by the write strobe, the read mux and the irq block
  function automatic dfr_sel_t regSel(input logic [15:0] idx);
    dfr_sel_t sel;
    sel = '0;
    if (idx == DEV_CODE_IDX) begin
      sel.dev = 1'b1;
    end else if (idx == LIM_CODE_IDX) begin
      sel.lim = 1'b1;
    end else if (idx == CMD_WORD_IDX) begin
      sel.cmd = 1'b1;
    end else if (idx == STAT_WORD_IDX) begin
      sel.stat = 1'b1;
    end else if (idx == IRQ_STAT_IDX) begin
      sel.irqSt = 1'b1;
    end else if (idx == IRQ_MASK_IDX) begin
      sel.irqMsk = 1'b1;
    end
    return sel;
  endfunction

  // pins pass two flip-flops before any logic sees them
  dfr_sync #(
    .W(NUM_PINS)
  ) u_sync (
    .mclk    (mclk),
    .rst     (rst),
    .pinIn   ({rampDone, limitHit, slipErr, followErr}),
    .syncOut (pinSync)
  );

  // rising edges of the synchronised pins
  assign pinRise = pinSync & ~s_r.pinPrev;
  assign devEv   = pinRise[PIN_FOLLOW] | pinRise[PIN_SLIP];
  assign limEv   = pinRise[PIN_LIMIT];
  assign rampEv  = pinRise[PIN_RAMP];
  assign irqSet  = {rampEv && (s_r.state == ST_BRAKE), limEv, devEv};

  // sticky events with write-one-clear and mask
  dfr_irq u_irq (
    .mclk   (mclk),
    .rst    (rst),
    .setEv  (irqSet),
    .statWr (s_r.wrPend && wrSel.irqSt),
    .maskWr (s_r.wrPend && wrSel.irqMsk),
    .wrData (hwdata[NUM_IRQ-1:0]),
    .stat   (irqStat),
    .mask   (irqMask),
    .irq    (irqLine)
  );

  // address phase decode; only aligned words inside the map window
  assign addrOk  = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00);
  assign addrIdx = haddr[17:2];
  assign take    = hsel && htrans[1] && hready;
  // one decoder for both bus phases keeps read and write maps identical
  assign rdSel   = regSel(addrIdx);
  assign wrSel   = regSel(s_r.wrIdx);

  // reaction for this cycle; a limit event outranks a deviation event
  always_comb begin
    react = '0;
    if (limEv) begin
      react = decodeCode(s_r.limCode, 1'b1);
    end else if (devEv) begin
      react = decodeCode(s_r.devCode, 1'b0);
    end
  end

  // bus, registers and drive state machine
  always_comb begin
    s_nxt         = s_r;
    s_nxt.ready   = 1'b1;
    s_nxt.resp    = 1'b0;
    s_nxt.pinPrev = pinSync;
    s_nxt.enaPrev = s_r.cmd[ENA_BIT];
    s_nxt.wrPend  = 1'b0;
    // data phase of a write; unmapped indices are dropped
    if (s_r.wrPend) begin
      if (wrSel.dev) begin
        s_nxt.devCode = hwdata[15:0];
      end else if (wrSel.lim) begin
        s_nxt.limCode = hwdata[15:0];
      end else if (wrSel.cmd) begin
        s_nxt.cmd = hwdata[15:0];
      end
    end
    // address phase: reads are latched now so the data phase has no wait
    if (take) begin
      s_nxt.wrPend = hwrite && addrOk;
      s_nxt.wrIdx  = addrIdx;
      s_nxt.rdata  = 32'h0000_0000;
      if (!hwrite && addrOk) begin
        if (rdSel.dev) begin
          s_nxt.rdata = {16'h0000, s_r.devCode};
        end else if (rdSel.lim) begin
          s_nxt.rdata = {16'h0000, s_r.limCode};
        end else if (rdSel.cmd) begin
          s_nxt.rdata = {16'h0000, s_r.cmd};
        end else if (rdSel.stat) begin
          s_nxt.rdata = {16'h0000, statusWord(s_r)};
        end else if (rdSel.irqSt) begin
          s_nxt.rdata = {29'h0000_0000, irqStat};
        end else if (rdSel.irqMsk) begin
          s_nxt.rdata = {29'h0000_0000, irqMask};
        end
      end
    end
    case (s_r.state)
      ST_RUN: begin
        if (limEv) begin
          s_nxt.warn = 1'b1;
        end
        // act only on a defined reaction
        if (react.act) begin
          if (react.coast) begin
            s_nxt.state       = ST_COAST;
            s_nxt.drv.powerEn = 1'b0;
          end else begin
            s_nxt.state          = ST_BRAKE;
            s_nxt.drv.brakeSlow  = !react.quick;
            s_nxt.drv.brakeQuick = react.quick;
            s_nxt.toHalt         = react.toHalt;
          end
        end
      end
      ST_BRAKE: begin
        // end of ramp; faults that arrive during the ramp are ignored, not held
        if (rampEv) begin
          s_nxt.drv.brakeSlow  = 1'b0;
          s_nxt.drv.brakeQuick = 1'b0;
          s_nxt.haltLowSeen    = 1'b0;
          if (s_r.toHalt) begin
            s_nxt.state = ST_HALT;
          end else begin
            s_nxt.state       = ST_LOCK;
            s_nxt.drv.powerEn = 1'b0;
          end
        end
      end
      ST_HALT: begin
        // the command word is only read here; the host rewrites it over the bus
        // wait for bit 2 low, then high again
        if (!s_r.cmd[HALT_BIT]) begin
          s_nxt.haltLowSeen = 1'b1;
        end else if (s_r.haltLowSeen) begin
          s_nxt.state       = ST_RUN;
          s_nxt.haltLowSeen = 1'b0;
          s_nxt.warn        = 1'b0;
        end
      end
      ST_COAST, ST_LOCK: begin
        // an enable edge from the host restarts the drive
        if (s_r.cmd[ENA_BIT] && !s_r.enaPrev) begin
          s_nxt.state       = ST_RUN;
          s_nxt.drv.powerEn = 1'b1;
          s_nxt.warn        = 1'b0;
        end
      end
      default: begin
        s_nxt.state = ST_LOCK;
        s_nxt.drv   = '0;
      end
    endcase
  end

  // registers; the drive starts locked until the host enables it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r         <= '0;
      s_r.state   <= ST_LOCK;
      s_r.devCode <= CODE_RST;
      s_r.limCode <= CODE_RST;
      s_r.cmd     <= CMD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // irq flop lives in the interrupt block
  assign hrdata     = s_r.rdata;
  assign hreadyout  = s_r.ready;
  assign hresp      = s_r.resp;
  assign powerEn    = s_r.drv.powerEn;
  assign brakeSlow  = s_r.drv.brakeSlow;
  assign brakeQuick = s_r.drv.brakeQuick;
  assign driveState = s_r.state;
  assign warning    = s_r.warn;
  assign irq        = irqLine;
endmodule

//--- tb/dfr_top_sva.sv
// port checker of the drive fault reaction selector
`timescale 1ns/1ps
module dfr_top_sva import dfr_pkg::*; (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // bus answer
  input wire logic       hreadyout,
  input wire logic       hresp,
  // pin
  input wire logic       limitHit,
  // drive control
  input wire logic       powerEn,
  input wire logic       brakeSlow,
  input wire logic       brakeQuick,
  input wire logic [4:0] driveState,
  input wire logic       warning
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // braking ends, or a limit pin rises while running
  sequence sBrakeEnd;
    driveState == ST_BRAKE ##1 driveState != ST_BRAKE;
  endsequence
  sequence sLimitRun;
    $rose(limitHit) && driveState == ST_RUN;
  endsequence
  // warning set and the drive stays out of run for two cycles
  sequence sWarnStopped;
    warning && driveState != ST_RUN ##1 driveState != ST_RUN;
  endsequence
  // power stage levels per state
  sequence sDriveOff;
    !powerEn && !brakeSlow && !brakeQuick;
  endsequence
  sequence sHoldPower;
    powerEn && !brakeSlow && !brakeQuick;
  endsequence
  sequence sOneRamp;
    powerEn && (brakeSlow != brakeQuick);
  endsequence
  // bus always answers at once with okay
  a_bus_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_zero_wait: assert property (!$past(rst) |-> hreadyout)
    else $error("bus stalled");
  // power stage outputs follow the drive state
  a_coast_off: assert property (driveState == ST_COAST |-> sDriveOff)
    else $error("coast drives the motor");
  a_lock_off: assert property (driveState == ST_LOCK |-> sDriveOff)
    else $error("locked drives the motor");
  a_halt_energised: assert property (driveState == ST_HALT |-> sHoldPower)
    else $error("halt not energised");
  a_brake_one_ramp: assert property (driveState == ST_BRAKE |-> sOneRamp)
    else $error("braking ramp choice wrong");
  a_brake_end: assert property (sBrakeEnd |-> driveState inside {ST_LOCK, ST_HALT})
    else $error("braking left to wrong state");
  // warning follows a limit passage within the pin latency
  a_limit_warn: assert property (sLimitRun |-> ##[1:4] warning)
    else $error("limit warning missing");
  a_warn_hold: assert property (sWarnStopped |-> warning)
    else $error("warning dropped");
endmodule
bind dfr_top dfr_top_sva chk_u (.mclk(mclk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
  .limitHit(limitHit), .powerEn(powerEn), .brakeSlow(brakeSlow), .brakeQuick(brakeQuick),
  .driveState(driveState), .warning(warning));

//--- tb/dfr_host.sv
// host controller model: single word bus master
`timescale 1ns/1ps
module dfr_host import dfr_pkg::*; (
  // clock and bus answer
  input  wire logic        mclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // bus request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // a bounded wait ran out
  output logic             hang
);
  logic [31:0] lastRd;
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    hang = 1'b0;
  end
  // ready and read data are taken at the rising edge, before that edge updates them
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge mclk);
    while (!hready && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (!hready) hang = 1'b1;
    lastRd = hrdata;
  endtask
  // one transfer; must be entered just after a rising edge
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {14'h0000, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
  endtask
  task automatic rearm();
    xfer(1'b1, CMD_WORD_IDX, 32'h0000_0000);
    xfer(1'b1, CMD_WORD_IDX, 32'h0000_0005);
  endtask
endmodule

//--- tb/dfr_top_tb.sv
// self-checking bench of the drive fault reaction selector
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module dfr_top_tb import dfr_pkg::*;;
  logic        mclk, rst, followErr, slipErr, limitHit, rampDone;
  logic        hsel, hwrite, hreadyout, hresp, hang;
  logic        powerEn, brakeSlow, brakeQuick, warning, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  driveState;
  logic [31:0] haddr, hwdata, hrdata;
  int          fails = 0;
  int          comparisons = 0;
  // cases 0..5 deviation, 6..11 limit switch; outputs are {power, slow, quick}
  logic [15:0] tCode [12] = '{16'hFFFF, 16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0003,
                              16'hFFFF, 16'h0001, 16'h0002, 16'h0005, 16'h0006, 16'h0004};
  logic [4:0]  tMid [12] = '{ST_RUN, ST_COAST, ST_BRAKE, ST_BRAKE, ST_RUN, ST_RUN,
                             ST_RUN, ST_BRAKE, ST_BRAKE, ST_BRAKE, ST_BRAKE, ST_RUN};
  logic [4:0]  tEnd [12] = '{ST_RUN, ST_COAST, ST_LOCK, ST_LOCK, ST_RUN, ST_RUN,
                             ST_RUN, ST_LOCK, ST_LOCK, ST_HALT, ST_HALT, ST_RUN};
  logic [2:0]  tOut [12] = '{3'h4, 3'h0, 3'h6, 3'h5, 3'h4, 3'h4,
                             3'h4, 3'h6, 3'h5, 3'h6, 3'h5, 3'h4};

  dfr_top dut_u (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .followErr(followErr), .slipErr(slipErr),
    .limitHit(limitHit), .rampDone(rampDone), .powerEn(powerEn), .brakeSlow(brakeSlow),
    .brakeQuick(brakeQuick), .driveState(driveState), .warning(warning), .irq(irq));
  dfr_host host_u (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hang(hang));

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // a stuck bus ends the run
  always @(posedge hang) begin
    fails++;
    complete_run();
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    host_u.xfer(1'b0, idx, 32'h0000_0000);
    `CHK(host_u.lastRd, exp)
  endtask
  // one fault with one code; pins settle three edges later
  task automatic run_case(input int i);
    if (driveState !== ST_RUN) begin
      host_u.rearm();
      cyc(3);
    end
    host_u.xfer(1'b1, i < 6 ? DEV_CODE_IDX : LIM_CODE_IDX, {16'h0000, tCode[i]});
    if (i >= 6) limitHit <= 1'b1;
    else if (i[0]) slipErr <= 1'b1;
    else followErr <= 1'b1;
    cyc(2);
    {limitHit, slipErr, followErr} <= 3'h0;
    cyc(3);
    `CHK(driveState, tMid[i])
    `CHK({powerEn, brakeSlow, brakeQuick}, tOut[i])
    if (i >= 6) `CHK(warning, 1'b1)
    if (tMid[i] === ST_BRAKE) begin
      rampDone <= 1'b1;
      cyc(2);
      rampDone <= 1'b0;
      cyc(3);
    end
    `CHK(driveState, tEnd[i])
    if (tEnd[i] === ST_HALT) rd_chk(CMD_WORD_IDX, 32'h0000_0005);
    if (tEnd[i] === ST_HALT) rd_chk(STAT_WORD_IDX, 32'h0000_0090);
  endtask

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    {followErr, slipErr, limitHit, rampDone} = 4'h0;
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    // reset values, a read-only place and an unmapped place
    rd_chk(DEV_CODE_IDX, 32'h0000_FFFF);
    rd_chk(LIM_CODE_IDX, 32'h0000_FFFF);
    host_u.xfer(1'b1, STAT_WORD_IDX, 32'h0000_00FF);
    rd_chk(STAT_WORD_IDX, 32'h0000_0008);
    rd_chk(16'h3706, 32'h0000_0000);
    for (int i = 0; i < 12; i++) run_case(i);
    // events were latched while masked, then signalled and cleared
    rd_chk(IRQ_STAT_IDX, 32'h0000_0007);
    `CHK(irq, 1'b0)
    host_u.xfer(1'b1, IRQ_MASK_IDX, 32'h0000_0002);
    cyc(2);
    `CHK(irq, 1'b1)
    host_u.xfer(1'b1, IRQ_STAT_IDX, 32'h0000_0007);
    cyc(2);
    `CHK(irq, 1'b0)
    rd_chk(IRQ_STAT_IDX, 32'h0000_0000);
    complete_run();
  end
endmodule
